// >>> design/atl_top.sv
// Purpose: Adaptive thermal limiter with trip offset and clock gating
// Assumes: Sensor readings arrive from another domain and move slowly
// Notes:   Protection has no disable; only the trip point is tunable
`timescale 1ns/1ps
module atl_top
   import atl_pkg::*;
#(
   parameter int          NUM_SENS = SENS_DEF,
   parameter int          LVL_W    = LVL_DEF,
   parameter logic [7:0]  JLIM     = JLIM_DEF,
   parameter int          HYST     = HYST_CYC
)(
   input  wire logic                       mclk,
   input  wire logic                       arst_n,
   input  wire logic [NUM_SENS*TEMP_W-1:0] dts_rel,
   input  wire logic [31:0]                msr_idx,
   input  wire logic                       msr_wr,
   input  wire logic                       msr_rd,
   input  wire logic [63:0]                msr_wdata,
   output logic      [63:0]                msr_rdata,
   output logic      [LVL_W-1:0]           core_freq_lvl,
   output logic      [LVL_W-1:0]           gfx_freq_lvl,
   output logic      [LVL_W-1:0]           volt_lvl,
   output logic                            clk_run,
   output logic                            tm_active,
   output logic                            tm_event,
   output logic      [TEMP_W-1:0]          trip_temp
);
   localparam int HW = $clog2(HYST + 1);
   localparam int SW = $clog2(STEP_CYC + 1);
   localparam logic [LVL_W-1:0] LMAX = {LVL_W{1'b1}};

   atl_op_if #(.LW(LVL_W)) op ();

   logic [NUM_SENS*TEMP_W-1:0] s1_r;
   logic [NUM_SENS*TEMP_W-1:0] s2_r;
   logic [OFS_W-1:0]           ofs_r;
   logic [TEMP_W-1:0]          trip_nxt;
   logic [TEMP_W-1:0]          trip_r;
   logic                       hot_nxt;
   logic                       hot_r;
   logic                       any_zero;
   atl_state_t                 state_r;
   atl_state_t                 state_nxt;
   logic [LVL_W-1:0]           tgt_r;
   logic [SW-1:0]              pace_r;
   logic                       step;
   logic [HW-1:0]              hyst_r;
   logic                       mod_r;
   logic                       event_r;
   logic [63:0]                rdata_r;
   logic                       tgt_hit;

   // ************************************************************
   // Sensor synchronisers
   // ************************************************************
   // Readings drift by a degree at a time, so bus skew only blurs
   // one sample; no handshake is worth its latency here
   // Reset to the coolest reading: zero means at the limit and
   // would trip the limiter right after reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= '1;
         s2_r <= '1;
      end else begin
         s1_r <= dts_rel;
         s2_r <= s1_r;
      end
   end

   // ************************************************************
   // Trip point and compare
   // ************************************************************
   assign trip_nxt = atl_sub_clamp(JLIM, TEMP_W'(ofs_r));

   always_comb begin
      hot_nxt  = 1'b0;
      any_zero = 1'b0;
      for (int i = 0; i < NUM_SENS; i++) begin
         if (atl_sub_clamp(JLIM, s2_r[i*TEMP_W +: TEMP_W]) >= trip_r) begin
            hot_nxt = 1'b1;
         end
         if (s2_r[i*TEMP_W +: TEMP_W] == 8'h00) begin
            any_zero = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         trip_r <= JLIM;
         hot_r  <= 1'b0;
      end else begin
         trip_r <= trip_nxt;
         hot_r  <= hot_nxt;
      end
   end

   // ************************************************************
   // Thermal target register
   // ************************************************************
   // Offset takes effect on the next compare, no restart needed
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ofs_r <= OFS_RST;
      end else if (msr_wr && msr_idx == TGT_IDX) begin
         ofs_r <= msr_wdata[OFS_LSB +: OFS_W];
      end
   end

   // Junction field comes from a constant: no write path reaches it
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= '0;
      end else if (msr_rd && msr_idx == TGT_IDX) begin
         rdata_r <= '0;
         rdata_r[JLIM_LSB +: JLIM_W] <= JLIM;
         rdata_r[OFS_LSB +: OFS_W]   <= ofs_r;
      end else begin
         rdata_r <= '0;
      end
   end

   // ************************************************************
   // Limiter state machine
   // ************************************************************
   // No enable bit exists, so a trip always engages the limiter
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (hot_r) begin
               state_nxt = ST_LIMIT;
            end
         end
         ST_LIMIT: begin
            if (!hot_r) begin
               state_nxt = ST_HYST;
            end else if (tgt_r == '0 && op.settled) begin
               state_nxt = ST_MOD;
            end
         end
         ST_MOD: begin
            if (!hot_r) begin
               state_nxt = ST_HYST;
            end
         end
         ST_HYST: begin
            if (hot_r) begin
               state_nxt = ST_LIMIT;
            end else if (hyst_r == '0) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Hysteresis keeps gating from chattering near the trip point
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hyst_r <= '0;
      end else if (state_r != ST_HYST) begin
         hyst_r <= HW'(HYST - 1);
      end else if (hyst_r != '0) begin
         hyst_r <= hyst_r - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mod_r <= 1'b0;
      end else if (state_nxt == ST_MOD) begin
         mod_r <= 1'b1;
      end else if (state_nxt == ST_IDLE || state_nxt == ST_LIMIT) begin
         mod_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         event_r <= 1'b0;
      end else begin
         event_r <= (state_r == ST_IDLE) && hot_r;
      end
   end

   // ************************************************************
   // Target level pacing
   // ************************************************************
   assign step = (pace_r == SW'(STEP_CYC - 1));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pace_r <= '0;
      end else begin
         pace_r <= step ? '0 : pace_r + 1'b1;
      end
   end

   // Lower while hot, hold in hysteresis, recover only when idle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tgt_r <= LMAX;
      end else if (step) begin
         if (hot_r && state_r != ST_IDLE && tgt_r != '0) begin
            tgt_r <= tgt_r - 1'b1;
         end else if (state_r == ST_IDLE && tgt_r != LMAX) begin
            tgt_r <= tgt_r + 1'b1;
         end
      end
   end

   // ************************************************************
   // Operating point and gating units
   // ************************************************************
   assign op.tgt    = tgt_r;
   assign op.mod_en = mod_r;

   atl_opstep #(.LW(LVL_W), .STEP(STEP_CYC)) u_step (
      .mclk   (mclk),
      .arst_n (arst_n),
      .op     (op)
   );

   atl_clkmod #(.PER(MOD_PER_CYC), .ON(MOD_ON_CYC)) u_mod (
      .mclk   (mclk),
      .arst_n (arst_n),
      .op     (op)
   );

   assign core_freq_lvl = op.freq;
   assign gfx_freq_lvl  = op.freq;
   assign volt_lvl      = op.volt;
   assign clk_run       = op.clk_on;
   assign tm_active     = (state_r != ST_IDLE);
   assign tm_event      = event_r;
   assign msr_rdata     = rdata_r;
   assign trip_temp     = trip_r;
   assign tgt_hit       = (tgt_r == '0);

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_tgt_read;
      msr_rd && msr_idx == TGT_IDX;
   endsequence
   sequence s_hot_step;
      hot_r && step && state_r != ST_IDLE && !tgt_hit;
   endsequence

   a_zero_reading_trips: assert property (
      (any_zero && trip_r == JLIM) |=> hot_r)
      else $error("zero reading did not trip");
   a_trip_no_wrap: assert property (
      trip_r <= JLIM && (!$stable(ofs_r) || ((TEMP_W'(ofs_r) >= JLIM)
      ? trip_r == 8'h00 : trip_r == JLIM - TEMP_W'(ofs_r))))
      else $error("trip point wrapped or wrong");
   a_jlim_readback: assert property (
      s_tgt_read |=> msr_rdata[JLIM_LSB +: JLIM_W] == JLIM
      && msr_rdata[OFS_LSB +: OFS_W] == $past(ofs_r))
      else $error("junction field read back wrong");
   a_ofs_write: assert property (
      (msr_wr && msr_idx == TGT_IDX)
      |=> ofs_r == $past(msr_wdata[OFS_LSB +: OFS_W]))
      else $error("offset write lost");
   a_event_on_entry: assert property (
      $rose(tm_active) |-> tm_event ##1 !tm_event)
      else $error("no single event on activation");
   a_hot_stays_active: assert property (
      hot_r |=> tm_active)
      else $error("monitor idle while hot");
   a_lower_while_hot: assert property (
      s_hot_step |=> tgt_r == $past(tgt_r) - 1'b1)
      else $error("target not lowered while hot");
   a_gate_only_at_min: assert property (
      $rose(mod_r) |-> tgt_hit ##1 (tgt_hit && op.mod_en))
      else $error("gating began above minimum point");
endmodule

// >>> pkg/atl_pkg.sv
// Purpose: Shared constants and types for the adaptive thermal limiter
// Assumes: Core clock mclk at 100 MHz
// Notes:   Every offset, field position, reset value and count lives here
package atl_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [31:0] TGT_IDX  = 32'h000001A2;
   localparam int          JLIM_LSB = 16;
   localparam int          JLIM_W   = 8;
   localparam int          OFS_LSB  = 24;
   localparam int          OFS_W    = 4;
   localparam logic [3:0]  OFS_RST  = 4'h0;
   localparam logic [7:0]  JLIM_DEF = 8'h69;
   localparam int          TEMP_W   = 8;
   localparam int          SENS_DEF = 4;
   localparam int          LVL_DEF  = 4;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_NS      = 10;
   localparam int MOD_PER_NS  = 32000;
   localparam int MOD_PER_CYC = MOD_PER_NS / CLK_NS;
   localparam int MOD_ON_PCT  = 25;
   localparam int MOD_ON_CYC  = MOD_PER_CYC * MOD_ON_PCT / 100;
   localparam int STEP_NS     = 1000;
   localparam int STEP_CYC    = STEP_NS / CLK_NS;
   localparam int HYST_NS     = 32000;
   localparam int HYST_CYC    = HYST_NS / CLK_NS;
   // ************************************************************
   // Types and helpers
   // ************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_LIMIT, ST_MOD, ST_HYST} atl_state_t;

   // Saturating subtract so a large offset never wraps the trip point
   function automatic logic [TEMP_W-1:0] atl_sub_clamp(
      input logic [TEMP_W-1:0] a,
      input logic [TEMP_W-1:0] b);
      return (b >= a) ? 8'h00 : a - b;
   endfunction
endpackage

// >>> pkg/atl_op_if.sv
// Purpose: Operating point and clock gating signals between limiter parts
// Assumes: One clock domain
// Notes:   Voltage level never sits below frequency level
`timescale 1ns/1ps
interface atl_op_if #(parameter int LW = 4);
   logic [LW-1:0] tgt;
   logic [LW-1:0] freq;
   logic [LW-1:0] volt;
   logic          settled;
   logic          mod_en;
   logic          clk_on;
   modport ctl (output tgt, mod_en, input freq, volt, settled, clk_on);
   modport pst (input tgt, output freq, volt, settled);
   modport cmd (input mod_en, output clk_on);
endinterface

// >>> design/atl_opstep.sv
// Purpose: Steps frequency and voltage levels toward a target level
// Assumes: Target changes no faster than the step pace
// Notes:   Frequency leads downward, voltage leads upward
`timescale 1ns/1ps
module atl_opstep
   import atl_pkg::*;
#(
   parameter int LW   = LVL_DEF,
   parameter int STEP = STEP_CYC
)(
   input wire logic mclk,
   input wire logic arst_n,
   atl_op_if.pst    op
);
   localparam int SW = $clog2(STEP + 1);
   localparam logic [LW-1:0] LMAX = {LW{1'b1}};

   logic [SW-1:0] pace_r;
   logic [LW-1:0] freq_r;
   logic [LW-1:0] volt_r;
   logic          tick;

   // ************************************************************
   // Step pacing
   // ************************************************************
   assign tick = (pace_r == SW'(STEP - 1));
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pace_r <= '0;
      end else begin
         pace_r <= tick ? '0 : pace_r + 1'b1;
      end
   end

   // ************************************************************
   // Level sequencing
   // ************************************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         freq_r <= LMAX;
         volt_r <= LMAX;
      end else if (tick) begin
         if (freq_r > op.tgt) begin
            freq_r <= freq_r - 1'b1;
         end else if (volt_r > freq_r && volt_r > op.tgt) begin
            volt_r <= volt_r - 1'b1;
         end else if (freq_r < volt_r) begin
            // Voltage already raised, so frequency may follow it up
            freq_r <= freq_r + 1'b1;
         end else if (volt_r < op.tgt) begin
            volt_r <= volt_r + 1'b1;
         end
      end
   end

   assign op.freq    = freq_r;
   assign op.volt    = volt_r;
   assign op.settled = (freq_r == op.tgt) && (volt_r == op.tgt);

   a_volt_over_freq: assert property (
      @(posedge mclk) disable iff (!arst_n) volt_r >= freq_r)
      else $error("voltage fell below frequency");
   a_freq_moves_first: assert property (
      @(posedge mclk) disable iff (!arst_n)
      (tick && freq_r > op.tgt) |=> (volt_r == $past(volt_r)))
      else $error("voltage moved before frequency on the way down");
endmodule

// >>> design/atl_clkmod.sv
// Purpose: Fixed duty clock gating for the last stage of thermal limiting
// Assumes: mod_en comes from the same clock
// Notes:   Period restarts whenever gating is enabled
`timescale 1ns/1ps
module atl_clkmod
   import atl_pkg::*;
#(
   parameter int PER = MOD_PER_CYC,
   parameter int ON  = MOD_ON_CYC
)(
   input wire logic mclk,
   input wire logic arst_n,
   atl_op_if.cmd    op
);
   localparam int CW = $clog2(PER + 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          clk_on_r;
   logic [CW-1:0] on_run_r;

   // ************************************************************
   // Duty counter
   // ************************************************************
   always_comb begin
      if (!op.mod_en) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = (cnt_r == CW'(PER - 1)) ? '0 : cnt_r + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Gate output from a flop so the clock enable never glitches
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         clk_on_r <= 1'b1;
      end else begin
         clk_on_r <= !op.mod_en || (cnt_nxt < CW'(ON));
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         on_run_r <= '0;
      end else begin
         on_run_r <= (op.mod_en && clk_on_r) ? on_run_r + 1'b1 : '0;
      end
   end

   assign op.clk_on = clk_on_r;

   a_duty_on_len: assert property (
      @(posedge mclk) disable iff (!arst_n)
      (op.mod_en && $fell(clk_on_r)) |-> (on_run_r == CW'(ON)))
      else $error("clock on phase has wrong length");
endmodule

// >>> bench/atl_sens_model.sv
// Purpose: Behavioural model of the on-die sensors feeding relative readings
// Assumes: Readings move at the falling edge, away from the sampling edge
// Notes:   One selectable sensor carries the commanded reading
`timescale 1ns/1ps
module atl_sens_model
   import atl_pkg::*;
#(
   parameter int         NUM_SENS = SENS_DEF,
   parameter logic [7:0] COOL_REL = 8'h40
)(
   input  wire logic                       mclk,
   input  wire logic [1:0]                 hot_sel,
   input  wire logic [7:0]                 hot_rel,
   output logic      [NUM_SENS*TEMP_W-1:0] dts_rel
);
   logic [3:0] tick_r;

   // Cool sensors wander by a degree so the link is never frozen
   initial begin
      tick_r  = 4'h0;
      dts_rel = {NUM_SENS{COOL_REL}};
      forever begin
         @(negedge mclk);
         tick_r <= tick_r + 4'h1;
         for (int i = 0; i < NUM_SENS; i++) begin
            dts_rel[i*TEMP_W +: TEMP_W] <= (i == hot_sel) ? hot_rel :
               COOL_REL + {7'h00, tick_r[3]};
         end
      end
   end
endmodule

// >>> bench/atl_top_tb.sv
// Purpose: Self-checking bench for the adaptive thermal limiter
// Assumes: Small junction limit so the clamp case is reachable
// Notes:   Hysteresis shortened to keep the run brief
`timescale 1ns/1ps
module atl_top_tb;
   import atl_pkg::*;
   localparam logic [7:0] JLIM_T = 8'h0C;
   localparam int         HYST_T = 20;

   logic                     mclk;
   logic                     arst_n;
   logic [SENS_DEF*TEMP_W-1:0] dts_rel;
   logic [31:0]              msr_idx;
   logic                     msr_wr;
   logic                     msr_rd;
   logic [63:0]              msr_wdata;
   logic [63:0]              msr_rdata;
   logic [3:0]               core_freq_lvl;
   logic [3:0]               gfx_freq_lvl;
   logic [3:0]               volt_lvl;
   logic                     clk_run;
   logic                     tm_active;
   logic                     tm_event;
   logic [7:0]               trip_temp;
   logic [1:0]               hot_sel;
   logic [7:0]               hot_rel;
   int                       n_mismatch;
   int                       n_checks;
   int                       n;

   atl_top #(.JLIM(JLIM_T), .HYST(HYST_T)) atl_top_inst (
      .mclk          (mclk),
      .arst_n        (arst_n),
      .dts_rel       (dts_rel),
      .msr_idx       (msr_idx),
      .msr_wr        (msr_wr),
      .msr_rd        (msr_rd),
      .msr_wdata     (msr_wdata),
      .msr_rdata     (msr_rdata),
      .core_freq_lvl (core_freq_lvl),
      .gfx_freq_lvl  (gfx_freq_lvl),
      .volt_lvl      (volt_lvl),
      .clk_run       (clk_run),
      .tm_active     (tm_active),
      .tm_event      (tm_event),
      .trip_temp     (trip_temp)
   );

   atl_sens_model atl_sens_model_inst (
      .mclk    (mclk),
      .hot_sel (hot_sel),
      .hot_rel (hot_rel),
      .dts_rel (dts_rel)
   );

   // ************************************************************
   // Checking and bus tasks
   // ************************************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic print_verdict;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [31:0] idx, input logic [63:0] d);
      @(negedge mclk);
      msr_idx   = idx;
      msr_wdata = d;
      msr_wr    = 1'b1;
      @(negedge mclk);
      msr_wr    = 1'b0;
   endtask

   // Strobe taken at the rising edge, data stands the following cycle
   task automatic reg_read(input logic [31:0] idx, input logic [63:0] exp);
      @(negedge mclk);
      msr_idx = idx;
      msr_rd  = 1'b1;
      @(negedge mclk);
      msr_rd  = 1'b0;
      check(msr_rdata, exp);
   endtask

   function automatic logic probe(input int sel);
      case (sel)
         0: return tm_active;
         1: return clk_run;
         2: return (core_freq_lvl == 4'h0) && (volt_lvl == 4'h0);
         default: return (core_freq_lvl == 4'hF) && (volt_lvl == 4'hF);
      endcase
   endfunction

   // A wait that runs out counts as a mismatch and ends the run
   task automatic wait_until(input int sel, input logic v, input int lim);
      int k;
      k = 0;
      while (probe(sel) !== v) begin
         @(negedge mclk);
         k++;
         if (k > lim) begin
            check(64'h0, 64'h1);
            print_verdict();
         end
      end
   endtask

   task automatic run_len(input logic v, input int lim, output int len);
      len = 0;
      while (clk_run === v) begin
         @(negedge mclk);
         len++;
         if (len > lim) begin
            check(64'h0, 64'h1);
            print_verdict();
         end
      end
   endtask

   // Ordering of the operating point is watched on every cycle
   always @(negedge mclk) begin
      if (arst_n === 1'b1) begin
         check({63'h0, volt_lvl >= core_freq_lvl}, 64'h1);
         check({60'h0, gfx_freq_lvl}, {60'h0, core_freq_lvl});
      end
   end

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      arst_n     = 1'b0;
      msr_idx    = TGT_IDX;
      msr_wr     = 1'b0;
      msr_rd     = 1'b0;
      msr_wdata  = 64'h0;
      hot_sel    = 2'd3;
      hot_rel    = 8'h40;
      n_mismatch = 0;
      n_checks   = 0;
      repeat (4) @(negedge mclk);
      arst_n = 1'b1;
      @(negedge mclk);
      check(trip_temp, JLIM_T);
      check({clk_run, tm_active, tm_event, core_freq_lvl, volt_lvl},
            {3'b100, 4'hF, 4'hF});
      reg_read(TGT_IDX, {36'h0, OFS_RST, JLIM_T, 16'h0});
      reg_read(32'h000001A3, 64'h0);
      // All ones save the offset field: only that field may take data; offset 5
      // keeps the trip below any platform trip point
      reg_write(TGT_IDX, 64'hFFFF_FFFF_F5FF_FFFF);
      repeat (3) @(negedge mclk);
      check(trip_temp, JLIM_T - 8'h05);
      reg_read(TGT_IDX, {36'h0, 4'h5, JLIM_T, 16'h0});
      hot_rel = 8'h06;
      repeat (30) @(negedge mclk);
      check(tm_active, 1'b0);
      hot_rel = 8'h05;
      n = 0;
      repeat (30) begin
         @(negedge mclk);
         n += tm_event;
      end
      check(tm_active, 1'b1);
      check(n, 1);
      wait_until(2, 1'b1, 8000);
      check(tm_active, 1'b1);
      wait_until(1, 1'b0, 3300);
      run_len(1'b0, 3000, n);
      check(n, MOD_PER_CYC - MOD_ON_CYC);
      run_len(1'b1, 1000, n);
      check(n, MOD_ON_CYC);
      hot_rel = 8'h20;
      wait_until(0, 1'b0, 3400);
      wait_until(3, 1'b1, 8000);
      check(clk_run, 1'b1);
      // Offset above the junction value must pin the trip at zero
      reg_write(TGT_IDX, 64'h0F00_0000);
      repeat (3) @(negedge mclk);
      check(trip_temp, 8'h00);
      wait_until(0, 1'b1, 20);
      // Offset back to zero: a reading of zero sits on the trip
      reg_write(TGT_IDX, 64'h0);
      wait_until(0, 1'b0, 100);
      check(trip_temp, JLIM_T);
      hot_rel = 8'h00;
      wait_until(0, 1'b1, 20);
      check(tm_event, 1'b1);
      print_verdict();
   end
endmodule
